// *** hw/high_speed_clock_select.v ***
// high-speed clock pin mode, range, stop control and clock selection
//
// How it works
// - reset leaves both high-speed pins as ports
// - unused high-speed clock keeps pins as ports
// - range bit: 0 low band, 1 high band
// - range bit accepts only first write after reset
// - range bit 1 stalls cpu five microseconds
// - ext 0, osc 1 gives resonator mode
// - ext 1, osc 1: first port, second input
// - clearing stop starts resonator oscillator
// - clearing stop enables external clock input
// - both select bits 1: high-speed drives both
// - high-speed main forces high-speed peripheral clock
// - cpu source 0 selects main system clock
// - divider codes 0..4 give divide 1..16
// - both select bits 0: internal oscillator drives
// - internal oscillator runs and feeds cpu
//
// clocks are carried as one-cycle ticks synchronous to clock_i;
// cpu_tick_o and periph_tick_o are the resulting clock enables.
`timescale 1ns/10ps
`include "hs_clk_map.vh"
module high_speed_clock_select
(
    input  wire       clock_i,
    input  wire       sys_rst_i,
    input  wire [2:0] addr_i,
    input  wire [7:0] wr_data_i,
    input  wire       wr_en_i,
    input  wire       rd_en_i,
    output reg  [7:0] rd_data_o,
    input  wire       ih_tick_i,
    input  wire       hs_tick_i,
    input  wire       sub_tick_i,
    output reg        cpu_tick_o,
    output reg        periph_tick_o,
    output reg        cpu_stalled_o,
    output reg        x1_port_mode_o,
    output reg        x2_port_mode_o,
    output reg        resonator_mode_o,
    output reg        ext_clk_mode_o,
    output reg        osc_run_o,
    output reg        ext_clk_en_o,
    output reg        gain_range_o,
    output reg        ih_osc_run_o,
    output reg        main_on_hs_o
);

    localparam integer STALL_INT = `GAIN_STALL_CYC;
    localparam [9:0]   STALL_CYC = STALL_INT[9:0]; // fits the counter
    localparam         STAB_W    = `OSC_STAB_BASE + `OSC_STAB_FLAGS;

    // cpu source mux codes, held as the active selection
    localparam [1:0] SRC_IH  = 2'h0;
    localparam [1:0] SRC_HS  = 2'h1;
    localparam [1:0] SRC_SUB = 2'h2;

    // control bits written by software
    reg              ext_clk_sel_q;
    reg              osc_pin_mode_sel_q;
    reg              gain_range_sel_q;
    reg              gain_locked_q;
    reg              hs_clk_stop_q;
    reg              main_clk_src_sel_q;
    reg              periph_clk_src_sel_q;
    reg              cpu_src_sel_q;
    reg  [2:0]       cpu_div_q;

    // internal state
    reg  [1:0]       cpu_src_act_q;
    reg  [1:0]       cpu_src_d;
    reg  [9:0]       stall_cnt_q;
    reg  [STAB_W-1:0] stab_cnt_q;
    reg  [`OSC_STAB_FLAGS-1:0] stab_flag_q;
    reg  [7:0]       rd_data_d;
    reg              src_tick;

    wire             wr_osc_ctrl;
    wire             wr_main_osc;
    wire             wr_main_mode;
    wire             wr_cpu_ctrl;
    wire             hs_running;
    wire             hs_tick_ok;
    wire             periph_on_hs;
    wire             div_tick;
    wire             div_wrap;
    wire             stalling;

    // write strobes per register
    assign wr_osc_ctrl  = wr_en_i & (addr_i == `ADDR_OSC_CTRL);
    assign wr_main_osc  = wr_en_i & (addr_i == `ADDR_MAIN_OSC_CTRL);
    assign wr_main_mode = wr_en_i & (addr_i == `ADDR_MAIN_CLK_MODE);
    assign wr_cpu_ctrl  = wr_en_i & (addr_i == `ADDR_CPU_CLK_CTRL);

    // high-speed clock is live in either pin mode once stop is cleared
    assign hs_running = osc_pin_mode_sel_q & ~hs_clk_stop_q;
    // ticks from a stopped source are dropped so they cannot leak
    assign hs_tick_ok = hs_tick_i & hs_running;

    // high-speed main clock overrides the peripheral select bit
    assign periph_on_hs = periph_clk_src_sel_q | main_clk_src_sel_q;

    assign stalling = (stall_cnt_q != 10'h000);

    // pin mode and range bits; mode bits are frozen while the clock runs,
    // since changing them under a live oscillator would upset the pads
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            ext_clk_sel_q      <= 1'b0;
            osc_pin_mode_sel_q <= 1'b0;
            gain_range_sel_q   <= `RST_GAIN_RANGE;
            gain_locked_q      <= 1'b0;
        end
        else if (wr_osc_ctrl)
        begin
            if (hs_clk_stop_q)
            begin
                ext_clk_sel_q      <= wr_data_i[`BIT_EXT_CLK_SEL];
                osc_pin_mode_sel_q <= wr_data_i[`BIT_OSC_PIN_MODE_SEL];
            end
            // only the first write after reset reaches the range bit
            if (!gain_locked_q)
            begin
                gain_range_sel_q <= wr_data_i[`BIT_GAIN_RANGE_SEL];
                gain_locked_q    <= 1'b1;
            end
        end
    end

    // cpu hold-off after the upper range is chosen
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            stall_cnt_q <= 10'h000;
        end
        else if (wr_osc_ctrl && !gain_locked_q &&
                 wr_data_i[`BIT_GAIN_RANGE_SEL])
        begin
            stall_cnt_q <= STALL_CYC;
        end
        else if (stalling)
        begin
            stall_cnt_q <= stall_cnt_q - 10'h001;
        end
    end

    // oscillator stop bit, stopped out of reset
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            hs_clk_stop_q <= `RST_HS_CLK_STOP;
        end
        else if (wr_main_osc)
        begin
            hs_clk_stop_q <= wr_data_i[`BIT_HS_CLK_STOP];
        end
    end

    // main and peripheral clock source bits
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            main_clk_src_sel_q   <= 1'b0;
            periph_clk_src_sel_q <= 1'b0;
        end
        else if (wr_main_mode)
        begin
            main_clk_src_sel_q   <= wr_data_i[`BIT_MAIN_CLK_SRC_SEL];
            periph_clk_src_sel_q <= wr_data_i[`BIT_PERIPH_CLK_SRC];
        end
    end

    // cpu source and ratio; prohibited codes are filtered in the divider
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cpu_src_sel_q <= 1'b0;
            cpu_div_q     <= `RST_CPU_DIV;
        end
        else if (wr_cpu_ctrl)
        begin
            cpu_src_sel_q <= wr_data_i[`BIT_CPU_SRC_SEL];
            cpu_div_q     <= wr_data_i[`MSB_CPU_DIV:`LSB_CPU_DIV];
        end
    end

    // requested cpu source from the select bits
    always @*
    begin
        if (cpu_src_sel_q)
        begin
            cpu_src_d = SRC_SUB;
        end
        else if (main_clk_src_sel_q)
        begin
            cpu_src_d = SRC_HS;
        end
        else
        begin
            cpu_src_d = SRC_IH;
        end
    end

    // the source is swapped only at the end of a divided period; a
    // limitation is that a dead source holds the cpu until it ticks
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cpu_src_act_q <= SRC_IH;
        end
        else if (div_wrap)
        begin
            cpu_src_act_q <= cpu_src_d;
        end
    end

    // tick stream feeding the cpu divider
    always @*
    begin
        case (cpu_src_act_q)
            SRC_HS:  src_tick = hs_tick_ok;
            SRC_SUB: src_tick = sub_tick_i;
            default: src_tick = ih_tick_i;
        endcase
    end

    // cpu clock divider; ratio taken at period end
    tick_divider
    #(
        .DEFAULT_CODE (`RST_CPU_DIV)
    )
    u_cpu_div
    (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .tick_i     (src_tick),
        .div_code_i (cpu_div_q),
        .tick_o     (div_tick),
        .wrap_o     (div_wrap)
    );

    // stabilisation counter, cleared whenever the clock is not running
    always @(posedge clock_i)
    begin
        if (sys_rst_i || !hs_running)
        begin
            stab_cnt_q <= {STAB_W{1'b0}};
        end
        else if (hs_tick_ok && !stab_flag_q[`OSC_STAB_FLAGS-1])
        begin
            stab_cnt_q <= stab_cnt_q + {{(STAB_W-1){1'b0}}, 1'b1};
        end
    end

    // sticky threshold flags, one per doubling of the wait
    genvar gi;
    generate
        for (gi = 0; gi < `OSC_STAB_FLAGS; gi = gi + 1)
        begin : g_stab
            always @(posedge clock_i)
            begin
                if (sys_rst_i || !hs_running)
                begin
                    stab_flag_q[gi] <= 1'b0;
                end
                else if (stab_cnt_q[`OSC_STAB_BASE+gi])
                begin
                    stab_flag_q[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // clock enables and pin state outputs, all registered
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cpu_tick_o       <= 1'b0;
            periph_tick_o    <= 1'b0;
            cpu_stalled_o    <= 1'b0;
            x1_port_mode_o   <= 1'b1;
            x2_port_mode_o   <= 1'b1;
            resonator_mode_o <= 1'b0;
            ext_clk_mode_o   <= 1'b0;
            osc_run_o        <= 1'b0;
            ext_clk_en_o     <= 1'b0;
            gain_range_o     <= 1'b0;
            ih_osc_run_o     <= 1'b0;
            main_on_hs_o     <= 1'b0;
        end
        else
        begin
            // cpu pulses are withheld whole during the hold-off
            cpu_tick_o     <= div_tick & ~stalling;
            cpu_stalled_o  <= stalling;
            // whole ticks only, so switching here never cuts a pulse
            periph_tick_o  <= periph_on_hs ? hs_tick_ok : ih_tick_i;
            // first pin is a port unless resonator mode
            x1_port_mode_o <= ~osc_pin_mode_sel_q | ext_clk_sel_q;
            x2_port_mode_o <= ~osc_pin_mode_sel_q;
            resonator_mode_o <= osc_pin_mode_sel_q & ~ext_clk_sel_q;
            ext_clk_mode_o <= osc_pin_mode_sel_q & ext_clk_sel_q;
            osc_run_o      <= hs_running & ~ext_clk_sel_q;
            ext_clk_en_o   <= hs_running & ext_clk_sel_q;
            gain_range_o   <= gain_range_sel_q;
            ih_osc_run_o   <= 1'b1;
            main_on_hs_o   <= (cpu_src_act_q == SRC_HS);
        end
    end

    // read mux, unmapped addresses answer zero
    always @*
    begin
        rd_data_d = 8'h00;
        if (addr_i == `ADDR_OSC_CTRL)
        begin
            rd_data_d[`BIT_EXT_CLK_SEL]      = ext_clk_sel_q;
            rd_data_d[`BIT_OSC_PIN_MODE_SEL] = osc_pin_mode_sel_q;
            rd_data_d[`BIT_GAIN_RANGE_SEL]   = gain_range_sel_q;
        end
        else if (addr_i == `ADDR_MAIN_OSC_CTRL)
        begin
            rd_data_d[`BIT_HS_CLK_STOP] = hs_clk_stop_q;
        end
        else if (addr_i == `ADDR_MAIN_CLK_MODE)
        begin
            rd_data_d[`BIT_MAIN_CLK_SRC_SEL] = main_clk_src_sel_q;
            rd_data_d[`BIT_MAIN_ON_HS_STAT]  = (cpu_src_act_q == SRC_HS);
            rd_data_d[`BIT_PERIPH_CLK_SRC]   = periph_on_hs;
        end
        else if (addr_i == `ADDR_CPU_CLK_CTRL)
        begin
            rd_data_d[`BIT_CPU_ON_SUB_STAT] = (cpu_src_act_q == SRC_SUB);
            rd_data_d[`BIT_CPU_SRC_SEL]     = cpu_src_sel_q;
            rd_data_d[`MSB_CPU_DIV:`LSB_CPU_DIV] = cpu_div_q;
        end
        else if (addr_i == `ADDR_OSC_STAB_STATUS)
        begin
            rd_data_d[`OSC_STAB_FLAGS-1:0] = stab_flag_q;
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            rd_data_o <= 8'h00;
        end
        else if (rd_en_i)
        begin
            rd_data_o <= rd_data_d;
        end
        else
        begin
            rd_data_o <= 8'h00;
        end
    end

endmodule

// *** hw/hs_clk_map.vh ***
// register map, field positions, reset values and timing counts
`ifndef HS_CLK_MAP_VH
`define HS_CLK_MAP_VH

// register addresses on the plain register port
`define ADDR_OSC_CTRL        3'h0
`define ADDR_MAIN_OSC_CTRL   3'h1
`define ADDR_MAIN_CLK_MODE   3'h2
`define ADDR_CPU_CLK_CTRL    3'h3
`define ADDR_OSC_STAB_STATUS 3'h4

// osc_ctrl_reg fields
`define BIT_EXT_CLK_SEL      7
`define BIT_OSC_PIN_MODE_SEL 6
`define BIT_GAIN_RANGE_SEL   0

// main_osc_ctrl_reg fields
`define BIT_HS_CLK_STOP      7

// main_clk_mode_reg fields
`define BIT_MAIN_CLK_SRC_SEL 2
`define BIT_MAIN_ON_HS_STAT  1
`define BIT_PERIPH_CLK_SRC   0

// cpu_clk_ctrl_reg fields
`define BIT_CPU_ON_SUB_STAT  5
`define BIT_CPU_SRC_SEL      4
`define MSB_CPU_DIV          2
`define LSB_CPU_DIV          0

// reset values
`define RST_HS_CLK_STOP      1'b1
`define RST_CPU_DIV          3'h1
`define RST_GAIN_RANGE       1'b0

// cpu divider codes
`define CPU_DIV_1            3'h0
`define CPU_DIV_2            3'h1
`define CPU_DIV_4            3'h2
`define CPU_DIV_8            3'h3
`define CPU_DIV_16           3'h4

// timing: clock period and cpu hold-off after selecting the upper range
`define CLK_PERIOD_NS        10
`define GAIN_STALL_NS        5000
`define GAIN_STALL_CYC       ((`GAIN_STALL_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)

// stabilisation status: first threshold is 2**OSC_STAB_BASE source ticks
`define OSC_STAB_BASE        11
`define OSC_STAB_FLAGS       5

`endif

// *** hw/tick_divider.v ***
// divides a stream of source ticks by a power of two, code taken at wrap
`timescale 1ns/10ps
module tick_divider
#(
    parameter [2:0] DEFAULT_CODE = 3'h1
)
(
    input  wire       clock_i,
    input  wire       sys_rst_i,
    input  wire       tick_i,
    input  wire [2:0] div_code_i,
    output reg        tick_o,
    output reg        wrap_o
);

    reg  [2:0] code_q;
    reg  [3:0] cnt_q;
    reg  [3:0] limit;
    reg        legal;

    // last count of the period for the code in use
    always @*
    begin
        case (code_q)
            3'h0:    limit = 4'h0;
            3'h1:    limit = 4'h1;
            3'h2:    limit = 4'h3;
            3'h3:    limit = 4'h7;
            default: limit = 4'hF;
        endcase
    end

    // prohibited codes are never loaded, the old ratio stays
    always @*
    begin
        legal = (div_code_i <= 3'h4);
    end

    // new ratio is taken only when a period ends, so no pulse is cut short
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            code_q <= DEFAULT_CODE;
            cnt_q  <= 4'h0;
            tick_o <= 1'b0;
            wrap_o <= 1'b0;
        end
        else
        begin
            tick_o <= 1'b0;
            wrap_o <= 1'b0;
            if (tick_i)
            begin
                if (cnt_q >= limit)
                begin
                    tick_o <= 1'b1;
                    wrap_o <= 1'b1;
                    cnt_q  <= 4'h0;
                    if (legal)
                    begin
                        code_q <= div_code_i;
                    end
                end
                else
                begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end

endmodule

// *** sim/hs_src_model.sv ***
// high-speed clock source stand-in: resonator or external clock generator
`timescale 1ns/10ps
module hs_src_model
(
    input  logic       clock_i,
    input  logic       run_i,
    input  logic [3:0] period_i,
    output logic       tick_o
);
    logic [3:0] cnt_q;

    // no ticks at all while stopped, so a stale source cannot leak through
    always @(posedge clock_i)
    begin
        cnt_q  <= (!run_i || cnt_q + 4'h1 >= period_i) ? 4'h0 : cnt_q + 4'h1;
        tick_o <= run_i && cnt_q == 4'h0;
    end
endmodule

// *** sim/hs_clk_monitor.sv ***
// concurrent checks on the high-speed clock selector ports
`timescale 1ns/10ps
module hs_clk_monitor
(
    input logic       clock_i,
    input logic       sys_rst_i,
    input logic [2:0] addr_i,
    input logic [7:0] wr_data_i,
    input logic       wr_en_i,
    input logic       rd_en_i,
    input logic [7:0] rd_data_o,
    input logic       ih_tick_i,
    input logic       hs_tick_i,
    input logic       sub_tick_i,
    input logic       cpu_tick_o,
    input logic       periph_tick_o,
    input logic       cpu_stalled_o,
    input logic       x1_port_mode_o,
    input logic       x2_port_mode_o,
    input logic       resonator_mode_o,
    input logic       ext_clk_mode_o,
    input logic       osc_run_o,
    input logic       ext_clk_en_o,
    input logic       gain_range_o,
    input logic       ih_osc_run_o
);
    int unsigned stall_n_q;
    logic        wr0_seen_q;
    logic [2:0]  wr0_dly_q;

    // stall length and first range write; the delay rides out output flops
    always @(posedge clock_i)
    begin
        stall_n_q  <= (sys_rst_i || !cpu_stalled_o) ? 0 : stall_n_q + 1;
        wr0_seen_q <= !sys_rst_i && (wr0_seen_q || (wr_en_i && addr_i == 3'h0));
        wr0_dly_q  <= sys_rst_i ? 3'h0 : {wr0_dly_q[1:0], wr0_seen_q};
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_release; $fell(sys_rst_i); endsequence
    sequence s_first_high;
        wr_en_i && addr_i == 3'h0 && wr_data_i[0] && !wr0_seen_q;
    endsequence

    property p_rst_ports; s_release |-> x1_port_mode_o && x2_port_mode_o; endproperty
    a_rst_ports: assert property (p_rst_ports) else $error("pins not ports");
    property p_ih_run; s_release |=> ih_osc_run_o; endproperty
    a_ih_run: assert property (p_ih_run) else $error("internal osc off");
    property p_reson;
        resonator_mode_o |-> !x1_port_mode_o && !x2_port_mode_o && !ext_clk_mode_o;
    endproperty
    a_reson: assert property (p_reson) else $error("resonator pins");
    property p_ext; ext_clk_mode_o |-> x1_port_mode_o && !x2_port_mode_o; endproperty
    a_ext: assert property (p_ext) else $error("ext clock pins");
    property p_osc_run; osc_run_o |-> resonator_mode_o && !ext_clk_en_o; endproperty
    a_osc_run: assert property (p_osc_run) else $error("osc run mode");
    property p_ext_en; ext_clk_en_o |-> ext_clk_mode_o; endproperty
    a_ext_en: assert property (p_ext_en) else $error("ext enable mode");
    property p_stall_go; s_first_high |-> ##[1:2] cpu_stalled_o; endproperty
    a_stall_go: assert property (p_stall_go) else $error("no stall");
    property p_stall_len; $fell(cpu_stalled_o) |-> stall_n_q >= 500; endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall short");
    property p_gain_lock; wr0_dly_q[2] |-> $stable(gain_range_o); endproperty
    a_gain_lock: assert property (p_gain_lock) else $error("range moved");
    property p_periph;
        periph_tick_o |-> $past(ih_tick_i) || $past(hs_tick_i);
    endproperty
    a_periph: assert property (p_periph) else $error("stray periph tick");
    property p_cpu;
        cpu_tick_o |-> $past(ih_tick_i, 2) || $past(hs_tick_i, 2) || $past(sub_tick_i, 2);
    endproperty
    a_cpu: assert property (p_cpu) else $error("stray cpu tick");
    property p_mode_rd;
        rd_en_i && addr_i == 3'h2 |=> !rd_data_o[2] || rd_data_o[0];
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("periph not hs");
endmodule

bind high_speed_clock_select hs_clk_monitor u_hs_clk_monitor
(
    .clock_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
    .ih_tick_i, .hs_tick_i, .sub_tick_i, .cpu_tick_o, .periph_tick_o,
    .cpu_stalled_o, .x1_port_mode_o, .x2_port_mode_o, .resonator_mode_o,
    .ext_clk_mode_o, .osc_run_o, .ext_clk_en_o, .gain_range_o, .ih_osc_run_o
);

// *** sim/tb.sv ***
// self-checking bench for the high-speed clock selector
`timescale 1ns/10ps
`include "hs_clk_map.vh"
module tb;
    logic        clock_i = 1'b0, sys_rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
    logic [2:0]  addr_i = 3'h0, code;
    logic [7:0]  wr_data_i = 8'h00, rd_data_o;
    logic        ih_tick_i = 1'b0, sub_tick_i = 1'b0, hs_tick_i, cpu_tick_o;
    logic        periph_tick_o, cpu_stalled_o, x1_port_mode_o, x2_port_mode_o;
    logic        resonator_mode_o, ext_clk_mode_o, osc_run_o, ext_clk_en_o;
    logic        gain_range_o, ih_osc_run_o, main_on_hs_o;
    logic [3:0]  hs_per = 4'h6, tcnt = 4'h0;
    logic [31:0] rnd_q = 32'h58;
    logic [7:0]  rst_val [0:7] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    int          err_total = 0, n_checks = 0, i, n, t;

    high_speed_clock_select u_high_speed_clock_select
    (
        .clock_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
        .ih_tick_i, .hs_tick_i, .sub_tick_i, .cpu_tick_o, .periph_tick_o,
        .cpu_stalled_o, .x1_port_mode_o, .x2_port_mode_o, .resonator_mode_o,
        .ext_clk_mode_o, .osc_run_o, .ext_clk_en_o, .gain_range_o,
        .ih_osc_run_o, .main_on_hs_o
    );
    hs_src_model u_hs_src_model
    (
        .clock_i, .run_i(osc_run_o | ext_clk_en_o), .period_i(hs_per), .tick_o(hs_tick_i)
    );

    // clock, internal ticks every 2 cycles, subsystem ticks every 4
    initial
        forever #5 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        tcnt       <= tcnt + 4'h1;
        ih_tick_i  <= tcnt[0];
        sub_tick_i <= tcnt[1:0] == 2'h3;
    end

    // the tests take some fourteen thousand cycles; this cuts a hang short
    initial
    begin
        #500000;
        err_total++;
        results;
    end

    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function int exp_per(input int base, input logic [2:0] c);
        return base << c;
    endfunction

    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_en_i   <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge clock_i);
        wr_en_i   <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        rd_en_i <= 1'b1;
        addr_i  <= a;
        @(posedge clock_i);
        rd_en_i <= 1'b0;
        #1;
        chk("rd_data_o", {8'h00, rd_data_o}, {8'h00, exp});
    endtask
    // pin modes are registered a cycle behind the control bits
    task pins(input logic [5:0] exp);
        repeat (3) @(posedge clock_i);
        #1;
        chk("pin modes", {10'h000, x1_port_mode_o, x2_port_mode_o, resonator_mode_o,
            ext_clk_mode_o, osc_run_o, ext_clk_en_o}, {10'h000, exp});
    endtask
    // skip three ticks so a ratio or source change taken at wrap has landed
    task per(input string nm, input logic sel, input int exp);
        int g;
        int k;
        int p;
        g = 0;
        k = 0;
        p = 0;
        while (k < 4 && g < 600)
        begin
            @(posedge clock_i);
            #1;
            g++;
            p += (k == 3);
            k += ((sel ? periph_tick_o : cpu_tick_o) === 1'b1);
        end
        chk(nm, p[15:0], exp[15:0]);
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        pins(6'h30);
        chk("ih_osc_run_o", {15'h0000, ih_osc_run_o}, 16'h0001);
        for (i = 0; i < 8; i++)
            rd(i[2:0], rst_val[i]);
        rnd_q = xs(rnd_q);
        wr(3'h4, rnd_q[7:0]);
        wr(3'h6, rnd_q[15:8]);
        rd(3'h4, 8'h00);
        $display("test reset and map done");
        per("cpu default", 1'b0, exp_per(2, `RST_CPU_DIV));
        per("periph internal", 1'b1, 2);
        for (i = 0; i < 8; i++)
        begin
            rnd_q = xs(rnd_q);
            code = (i < 5) ? i[2:0] : 3'(rnd_q % 5);
            wr(3'h3, {5'h00, code});
            per("cpu ratio", 1'b0, exp_per(2, code));
        end
        wr(3'h3, {5'h00, 3'h5 + 3'(rnd_q % 3)});
        per("cpu bad ratio", 1'b0, exp_per(2, code));
        wr(3'h3, 8'h10);
        per("cpu on sub", 1'b0, 4);
        wr(3'h3, 8'h00);
        $display("test divider done");
        wr(3'h0, 8'h41);
        n = 0;
        t = 0;
        repeat (600)
        begin
            @(posedge clock_i);
            #1;
            n += (cpu_stalled_o === 1'b1);
            t += (n > 2 && cpu_stalled_o === 1'b1 && cpu_tick_o !== 1'b0);
        end
        chk("stall cycles", n[15:0], 16'(`GAIN_STALL_CYC));
        chk("ticks in stall", t[15:0], 16'h0000);
        wr(3'h0, 8'h40);
        rd(3'h0, 8'h41);
        chk("gain_range_o", {15'h0000, gain_range_o}, 16'h0001);
        pins(6'h08);
        wr(3'h1, 8'h00);
        pins(6'h0A);
        wr(3'h0, 8'hC1);
        pins(6'h0A);
        // software waits for the first stabilisation flag before use
        repeat ((1 << `OSC_STAB_BASE) * hs_per - 300) @(posedge clock_i);
        rd(3'h4, 8'h00);
        repeat (500) @(posedge clock_i);
        rd(3'h4, 8'h01);
        wr(3'h2, 8'h05);
        per("periph on hs", 1'b1, 6);
        per("cpu on hs", 1'b0, 6);
        chk("main_on_hs_o", {15'h0000, main_on_hs_o}, 16'h0001);
        wr(3'h2, 8'h04);
        rd(3'h2, 8'h07);
        per("periph forced hs", 1'b1, 6);
        wr(3'h2, 8'h00);
        per("cpu on internal", 1'b0, 2);
        chk("main_on_hs_o", {15'h0000, main_on_hs_o}, 16'h0000);
        $display("test resonator done");
        wr(3'h1, 8'h80);
        wr(3'h0, 8'hC0);
        pins(6'h24);
        hs_per = 4'h2;
        wr(3'h1, 8'h00);
        pins(6'h25);
        wr(3'h2, 8'h05);
        per("periph on ext", 1'b1, 2);
        wr(3'h2, 8'h00);
        wr(3'h1, 8'h80);
        wr(3'h0, 8'h00);
        pins(6'h30);
        $display("test external clock done");
        results;
    end
endmodule
